/* File: hdl/sadc_sequencer.sv */
// SAR converter sequencer: control/result registers, marker shifting, sleep handling
//
// The plain strobed port and the placing of the registers were decided locally.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Previous result stays readable while the next conversion samples.
// - After sampling, result clears and a single marker one is loaded in the same cycle.
// - Each decided bit shifts marker right and fills the vacated position.
// - After nine marker shifts and three settle periods the conversion completes and go clears.
// - Software clearing go aborts at once, no done flag.
// - Abort leaves partial result; marker position shows bits converted.
// - Clock select bits 7:6 pick divide by 16, 8 or 4; code 3 also divides by 4.
// - Bit 0 powers the converter; clear means fully off.
// - Sleep entry clears go and power bits, halting conversion.
// - Sleep, wake and reset set clock and channel fields to ones.
// - Sleep abort keeps partial result only if a bit was decided.
// - Normal completion clears go and sets the done flag.
// - Setting go is ignored while power bit is clear.
// - Every completed conversion lasts exactly thirteen bit periods.
// - Channel changes apply only after the current conversion.
module sadc_sequencer
    import sadc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    // Power management
    input  wire logic       sleep_enter,
    input  wire logic       wake,
    // Analog front end
    input  wire logic       comparator_in,
    output logic            converter_power_on,
    output logic            sample_enable,
    output logic [2:0]      channel_route,
    output logic            channel_valid,
    output logic [7:0]      dac_code,
    output logic [7:0]      analog_pin_select,
    // Interrupt
    output logic            irq
);
    typedef struct packed {
        sadc_state_t state;
        logic [7:0]  control;
        logic [7:0]  result;
        logic [7:0]  marker;
        logic [7:0]  ansel;
        logic [7:0]  mask;
        logic        done_flag;
        logic [1:0]  clk_run;
        logic [3:0]  chan_run;
        logic [3:0]  periods;
        logic [3:0]  shifts;
        logic        decided;
        logic [7:0]  rdata;
        logic        irq;
        logic        cmp_meta;
        logic        cmp_sync;
        logic        sleep_meta;
        logic        sleep_sync;
        logic        sleep_prev;
        logic        wake_meta;
        logic        wake_sync;
        logic        wake_prev;
    } sadc_regs_t;

    sadc_regs_t st_reg;
    sadc_regs_t st_next;
    sadc_bus_t  bus;
    logic       tick;
    logic       running;
    logic       sleep_edge;
    logic       wake_edge;

    assign bus = '{write: reg_write, read: reg_read, addr: reg_addr, wdata: reg_wdata};
    assign running = (st_reg.state != SADC_IDLE);
    assign sleep_edge = st_reg.sleep_sync && !st_reg.sleep_prev;
    assign wake_edge  = st_reg.wake_sync && !st_reg.wake_prev;

    // Divisor latched at start so a mid-conversion change waits
    sadc_divider u_divider (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .run     (running),
        .clk_sel (st_reg.clk_run),
        .tick    (tick)
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.cmp_meta   = comparator_in;
        st_next.cmp_sync   = st_reg.cmp_meta;
        st_next.sleep_meta = sleep_enter;
        st_next.sleep_sync = st_reg.sleep_meta;
        st_next.sleep_prev = st_reg.sleep_sync;
        st_next.wake_meta  = wake;
        st_next.wake_sync  = st_reg.wake_meta;
        st_next.wake_prev  = st_reg.wake_sync;
        st_next.rdata      = 8'h00;

        // Register writes
        if (bus.write) begin
            case (bus.addr)
                ADDR_CONTROL: begin
                    st_next.control = bus.wdata;
                    // Go only sticks when power is on
                    if (!bus.wdata[POWER_BIT]) begin
                        st_next.control[GO_BIT] = 1'b0;
                    end
                end
                ADDR_RESULT: st_next.result = bus.wdata;
                ADDR_MASK:   st_next.mask   = bus.wdata;
                default:     st_next.ansel  = bus.wdata;
            endcase
        end

        // Sequencer
        case (st_reg.state)
            SADC_IDLE: begin
                if (st_next.control[GO_BIT] && st_next.control[POWER_BIT]) begin
                    st_next.state    = SADC_SAMPLE;
                    st_next.clk_run  = st_next.control[CLK_SEL_HI:CLK_SEL_LO];
                    st_next.chan_run = st_next.control[CHAN_HI:CHAN_LO];
                    st_next.periods  = 4'h0;
                    st_next.shifts   = 4'h0;
                    st_next.decided  = 1'b0;
                end
            end
            SADC_SAMPLE: begin
                // Old result untouched while sampling
                if (tick) begin
                    st_next.periods = st_reg.periods + 4'h1;
                    if (st_reg.periods + 4'h1 >= SAMPLE_PERIODS) begin
                        st_next.state  = SADC_SHIFT;
                        st_next.result = RESULT_RESET;
                        st_next.marker = MARKER_START;
                    end
                end
            end
            SADC_SHIFT: begin
                if (tick) begin
                    st_next.periods = st_reg.periods + 4'h1;
                    st_next.shifts  = st_reg.shifts + 4'h1;
                    st_next.marker  = st_reg.marker >> 1;
                    // Decided bit lands where the marker stood
                    st_next.result  = (st_reg.result & ~st_reg.marker) |
                                      (st_reg.cmp_sync ? st_reg.marker : 8'h00);
                    st_next.decided = st_reg.decided || (st_reg.marker != 8'h00);
                    if (st_reg.shifts + 4'h1 >= SHIFT_COUNT) begin
                        st_next.state = SADC_TAIL;
                    end
                end
            end
            SADC_TAIL: begin
                if (tick) begin
                    st_next.periods = st_reg.periods + 4'h1;
                    if (st_reg.periods + 4'h1 >= PERIODS_TOTAL) begin
                        st_next.state = SADC_IDLE;
                        st_next.control[GO_BIT] = 1'b0;
                        st_next.done_flag = 1'b1;
                    end
                end
            end
            default: st_next.state = SADC_IDLE;
        endcase

        // Software abort keeps the partial result
        if (running && !st_next.control[GO_BIT] && st_next.state != SADC_IDLE) begin
            st_next.state = SADC_IDLE;
        end

        // Sleep entry: stop, power down, fields to ones
        if (sleep_edge) begin
            st_next.control[GO_BIT]    = 1'b0;
            st_next.control[POWER_BIT] = 1'b0;
            st_next.control[CLK_SEL_HI:CHAN_LO] = CONTROL_RESET[CLK_SEL_HI:CHAN_LO];
            st_next.state = SADC_IDLE;
            // Nothing decided yet: no partial data is claimed
            if (st_reg.state == SADC_SHIFT && !st_reg.decided) begin
                st_next.result = RESULT_RESET;
            end
        end
        if (wake_edge) begin
            st_next.control = CONTROL_RESET;
            st_next.ansel   = ANSEL_RESET;
        end

        // Reads; status clears on read but a same-cycle set wins if the flag was clear
        if (bus.read) begin
            case (bus.addr)
                ADDR_CONTROL: st_next.rdata = st_reg.control;
                ADDR_RESULT:  st_next.rdata = st_reg.result;
                ADDR_MASK:    st_next.rdata = st_reg.mask;
                default: begin
                    st_next.rdata = {7'h00, st_reg.done_flag};
                    if (!(st_reg.state == SADC_TAIL && st_next.state == SADC_IDLE
                          && st_next.done_flag && !st_reg.done_flag)) begin
                        st_next.done_flag = 1'b0;
                    end
                end
            endcase
        end
        st_next.irq = st_next.done_flag && st_next.mask[0];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.state   <= SADC_IDLE;
            st_reg.control <= CONTROL_RESET;
            st_reg.ansel   <= ANSEL_RESET;
            st_reg.mask    <= MASK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Front end outputs, all from flip-flops
    logic [7:0] trial_q;
    logic       samp_q;
    logic [2:0] route_q;
    logic       route_ok_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trial_q    <= 8'h00;
            samp_q     <= 1'b0;
            route_q    <= 3'h0;
            route_ok_q <= 1'b0;
        end else begin
            trial_q    <= st_next.result | st_next.marker;
            samp_q     <= st_next.state == SADC_SAMPLE;
            route_q    <= st_next.chan_run[2:0];
            route_ok_q <= !st_next.chan_run[3];
        end
    end

    assign converter_power_on = st_reg.control[POWER_BIT];
    assign sample_enable      = samp_q;
    assign channel_route      = route_q;
    assign channel_valid      = route_ok_q;
    assign dac_code           = trial_q;
    assign analog_pin_select  = st_reg.ansel;
    assign reg_rdata          = st_reg.rdata;
    assign irq                = st_reg.irq;
endmodule
`default_nettype wire

/* File: common/sadc_pkg.sv */
// Package of constants, types and register map for the SAR converter sequencer
`default_nettype none
package sadc_pkg;
    // Register map (word index on the plain register port)
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_RESULT  = 2'h1;
    localparam logic [1:0] ADDR_STATUS  = 2'h2;
    localparam logic [1:0] ADDR_MASK    = 2'h3;
    localparam logic [1:0] ADDR_ANSEL   = 2'h2;

    // Control register fields
    localparam int CLK_SEL_HI  = 7;
    localparam int CLK_SEL_LO  = 6;
    localparam int CHAN_HI     = 5;
    localparam int CHAN_LO     = 2;
    localparam int GO_BIT      = 1;
    localparam int POWER_BIT   = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'hFC;
    localparam logic [7:0] RESULT_RESET  = 8'h00;
    localparam logic [7:0] ANSEL_RESET   = 8'hFF;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [7:0] MARKER_START  = 8'h80;

    // Clock select codes
    localparam logic [1:0] CS_DIV16 = 2'h0;
    localparam logic [1:0] CS_DIV8  = 2'h1;
    localparam logic [1:0] CS_DIV4  = 2'h2;
    localparam logic [1:0] CS_OSC4  = 2'h3;

    // Instruction clock is mclk / 4; bit period is that divided further
    localparam logic [5:0] DIV16_TERM = 6'h3F;
    localparam logic [5:0] DIV8_TERM  = 6'h1F;
    localparam logic [5:0] DIV4_TERM  = 6'h0F;

    // Bit periods per conversion: 1 sample, 9 marker shifts, 3 settle
    localparam logic [3:0] PERIODS_TOTAL  = 4'hD;
    localparam logic [3:0] SAMPLE_PERIODS = 4'h1;
    localparam logic [3:0] SHIFT_COUNT    = 4'h9;

    typedef enum logic [1:0] {
        SADC_IDLE   = 2'b00,
        SADC_SAMPLE = 2'b01,
        SADC_SHIFT  = 2'b11,
        SADC_TAIL   = 2'b10
    } sadc_state_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [1:0] addr;
        logic [7:0] wdata;
    } sadc_bus_t;

    typedef struct packed {
        logic       powered;
        logic       sample;
        logic [2:0] channel;
    } sadc_front_t;
endpackage
`default_nettype wire

/* File: hdl/sadc_divider.sv */
// Bit-period tick divider for the SAR converter sequencer
`default_nettype none
module sadc_divider
    import sadc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] clk_sel,
    // Output
    output logic            tick
);
    typedef struct packed {
        logic [5:0] count;
        logic       tick;
    } sadc_div_t;

    sadc_div_t state_reg;
    sadc_div_t state_next;
    logic [5:0] terminal;

    always_comb begin
        case (clk_sel)
            CS_DIV16: terminal = DIV16_TERM;
            CS_DIV8:  terminal = DIV8_TERM;
            default:  terminal = DIV4_TERM;
        endcase
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.count = 6'h00;
        end else if (state_reg.count >= terminal) begin
            state_next.count = 6'h00;
            state_next.tick  = 1'b1;
        end else begin
            state_next.count = state_reg.count + 6'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule
`default_nettype wire

/* File: testbench/sadc_sequencer_properties.sv */
// Port-level checks on the SAR converter sequencer
`default_nettype none
module sadc_sequencer_properties
    import sadc_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Power management
    input wire logic       sleep_enter,
    input wire logic       wake,
    // Analog front end
    input wire logic       comparator_in,
    input wire logic       converter_power_on,
    input wire logic       sample_enable,
    input wire logic [2:0] channel_route,
    input wire logic       channel_valid,
    input wire logic [7:0] dac_code,
    input wire logic [7:0] analog_pin_select,
    // Interrupt
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic ctl_wr;
    assign ctl_wr = reg_write && reg_addr == ADDR_CONTROL;
    a_sample_powered: assert property (sample_enable |-> converter_power_on)
        else $error("sampling while unpowered");
    a_power_write: assert property (ctl_wr && reg_wdata[POWER_BIT] && !sleep_enter |-> ##[1:2] converter_power_on)
        else $error("power bit write not applied");
    a_go_ignored: assert property (ctl_wr && reg_wdata[1:0] == 2'b10 && !converter_power_on |-> !sample_enable [*4])
        else $error("go accepted while unpowered");
    a_abort_stops: assert property (ctl_wr && !reg_wdata[GO_BIT] |-> ##2 !sample_enable)
        else $error("conversion kept running after abort");
    a_sample_length: assert property ($rose(sample_enable) |-> sample_enable [*8])
        else $error("sampling phase too short");
    a_marker_load: assert property ($fell(sample_enable) && converter_power_on && !$past(reg_write)
        && !$past(reg_write, 2) |-> ##[0:2] dac_code == MARKER_START)
        else $error("marker not loaded after sampling");
    a_route_stable: assert property (sample_enable && $past(sample_enable) |-> $stable(channel_route))
        else $error("channel changed during conversion");
    a_sleep_off: assert property ($rose(sleep_enter) |-> ##[1:5] !converter_power_on)
        else $error("converter still powered in sleep");
    a_status_clear: assert property (reg_read && reg_addr == ADDR_STATUS |-> ##[1:3] !irq)
        else $error("interrupt survived status read");
    a_irq_idle: assert property ($rose(irq) |-> !sample_enable)
        else $error("done raised while sampling");
endmodule
`default_nettype wire

/* File: testbench/sadc_front_model.sv */
// Comparator front end model for the SAR converter sequencer
`default_nettype none
module sadc_front_model (
    // Input level as a code, trial code from the sequencer
    input  wire logic [7:0] level,
    input  wire logic [7:0] dac_code,
    input  wire logic       powered,
    // Comparator answer
    output logic            comparator_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Level sits half a step above its code, so a trial never ties with it
    // High means the trial is not above the input, so the sequencer keeps the bit
    assign comparator_in = powered && ({level, 1'b1} > {dac_code, 1'b0});
endmodule
`default_nettype wire

/* File: testbench/sadc_sequencer_tb.sv */
// Self-checking bench for the SAR converter sequencer
`default_nettype none
module sadc_sequencer_tb
    import sadc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [1:0] sel;
        logic [2:0] chan;
        logic [7:0] level;
        logic [7:0] period;
    } sadc_row_t;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       sleep_enter = 1'b0;
    logic       wake = 1'b0;
    logic [7:0] level = 8'h00;
    sadc_bus_t  bus = '0;
    logic [7:0] rdata, pin_sel, dac;
    logic       power, sample, valid, irq, cmp;
    logic [2:0] route;
    int         fails = 0;
    int         samples_checked = 0;
    int         n;
    // Software side picks the divisor; rows use every clock select code
    sadc_row_t  rows [4] = '{'{2'h2, 3'h0, 8'hA5, 8'h10}, '{2'h3, 3'h7, 8'h00, 8'h10},
                             '{2'h1, 3'h3, 8'hFF, 8'h20}, '{2'h0, 3'h5, 8'h5A, 8'h40}};
    always #4 mclk = ~mclk;
    sadc_sequencer dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(bus.addr), .reg_wdata(bus.wdata),
        .reg_write(bus.write), .reg_read(bus.read), .reg_rdata(rdata), .sleep_enter(sleep_enter),
        .wake(wake), .comparator_in(cmp), .converter_power_on(power), .sample_enable(sample),
        .channel_route(route), .channel_valid(valid), .dac_code(dac), .analog_pin_select(pin_sel), .irq(irq));
    sadc_front_model u_front (.level(level), .dac_code(dac), .powered(power), .comparator_in(cmp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        bus <= '0;
        #1 d = rdata;
        @(posedge mclk);
    endtask
    task automatic expect_reg(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge mclk);
            #1 n++;
            if (n > 2000) begin
                fails++;
                end_sim();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        expect_reg(ADDR_CONTROL, CONTROL_RESET);
        check(pin_sel, 8'hFF);
        wr(ADDR_CONTROL, 8'h02);
        expect_reg(ADDR_CONTROL, 8'h00);
        wr(ADDR_MASK, 8'h01);
        foreach (rows[i]) begin
            level <= rows[i].level;
            wr(ADDR_CONTROL, {rows[i].sel, 1'b0, rows[i].chan, 2'b11});
            wait_irq();
            check(8'(n >= 13 * rows[i].period - 4 && n <= 13 * rows[i].period + 8), 8'h01);
            check({5'h0, route}, {5'h0, rows[i].chan});
            check({7'h0, valid}, 8'h01);
            expect_reg(ADDR_RESULT, rows[i].level);
            expect_reg(ADDR_CONTROL, {rows[i].sel, 1'b0, rows[i].chan, 2'b01});
            expect_reg(ADDR_STATUS, 8'h01);
            check({7'h0, irq}, 8'h00);
        end
        // Masked completion, old result while sampling, late channel change
        wr(ADDR_MASK, 8'h00);
        level <= 8'h33;
        wr(ADDR_CONTROL, 8'h87);
        expect_reg(ADDR_RESULT, 8'h5A);
        wr(ADDR_CONTROL, 8'h8B);
        check({5'h0, route}, 8'h01);
        repeat (230) @(posedge mclk);
        check({7'h0, irq}, 8'h00);
        expect_reg(ADDR_RESULT, 8'h33);
        expect_reg(ADDR_STATUS, 8'h01);
        expect_reg(ADDR_STATUS, 8'h00);
        wr(ADDR_MASK, 8'h01);
        // Abort in mid-conversion keeps the decided bits
        level <= 8'hC3;
        wr(ADDR_CONTROL, 8'h83);
        repeat (80) @(posedge mclk);
        wr(ADDR_CONTROL, 8'h81);
        rd(ADDR_RESULT, d);
        check({6'h0, d[7:6]}, 8'h03);
        repeat (300) @(posedge mclk);
        check({7'h0, irq}, 8'h00);
        expect_reg(ADDR_STATUS, 8'h00);
        // Sleep in mid-conversion, then wake
        wr(ADDR_ANSEL, 8'h0F);
        wr(ADDR_CONTROL, 8'h83);
        repeat (80) @(posedge mclk);
        sleep_enter <= 1'b1;
        repeat (8) @(posedge mclk);
        check({7'h0, power}, 8'h00);
        expect_reg(ADDR_CONTROL, 8'hFC);
        check(pin_sel, 8'h0F);
        rd(ADDR_RESULT, d);
        check({6'h0, d[7:6]}, 8'h03);
        sleep_enter <= 1'b0;
        wake <= 1'b1;
        repeat (8) @(posedge mclk);
        wake <= 1'b0;
        check(pin_sel, 8'hFF);
        expect_reg(ADDR_CONTROL, 8'hFC);
        end_sim();
    end
endmodule
bind sadc_sequencer sadc_sequencer_properties u_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sleep_enter(sleep_enter), .wake(wake), .comparator_in(comparator_in), .converter_power_on(converter_power_on),
    .sample_enable(sample_enable), .channel_route(channel_route), .channel_valid(channel_valid),
    .dac_code(dac_code), .analog_pin_select(analog_pin_select), .irq(irq));
`default_nettype wire
